// File: src/wdw_watchdog.sv
// Windowed watchdog with write-once configuration window
// Summary of operation
// - Each configuration byte register accepts one write per configuration window.
// - A counter reaching the timeout value without refresh raises the system reset.
// - A new configuration window opens after the first only if updates were allowed.
// - The watchdog can be switched off only while the update-allow bit is one.
// - The timeout is a 16-bit tick count held as a high and a low byte.
// - A 16-bit window value rejects refreshes that come too early in window mode.
// - A timeout sets a software-clearable flag, gated by an interrupt enable bit.
// - A read-only flag shows that the counter is running.
// - The present counter value is readable at all times.
`timescale 1ns/1ps
`default_nettype none
module wdw_watchdog
    import wdw_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              unlockReq,
    input  wire logic              refreshReq,
    input  wire logic              cfgWr,
    input  wire logic [SEL_W-1:0]  cfgSel,
    input  wire logic [BYTE_W-1:0] cfgData,
    input  wire logic              irqFlagClear,
    input  wire logic              extTick,
    output logic                   configWindowOpen,
    output logic                   updateAllowed,
    output logic                   timeoutIrqFlag,
    output logic                   timeoutIrqReq,
    output logic                   counterRunningFlag,
    output logic [CNT_W-1:0]       counterValue,
    output logic                   systemReset
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0]          rstSync;
    logic                rstN;
    wdw_win_e            winState;
    logic [CNT_W-1:0]    winTimer;
    logic [NUM_REGS-1:0] written;
    logic [BYTE_W-1:0]   ctrlReg;
    logic [CNT_W-1:0]    timeoutVal;
    logic [CNT_W-1:0]    windowVal;
    logic                wrOk;
    logic                unlockOk;
    logic                tick;
    logic                timeoutEv;
    logic                refreshOk;
    logic                refreshBad;
    logic [BYTE_W-1:0]   next_ctrl;

    wdw_tick_if tickIf ();

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration window
    assign unlockOk = unlockReq && winState == WIN_CLOSED && ctrlReg[CTRL_UPD];
    // Selects above the last register are dropped before they index the write mask
    assign wrOk     = cfgWr && winState == WIN_OPEN && cfgSel < SEL_W'(NUM_REGS)
                      && !written[cfgSel];

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            winState <= WIN_OPEN;
            winTimer <= CNT_ZERO;
        end
        else if (unlockOk)
        begin
            winState <= WIN_OPEN;
            winTimer <= CNT_ZERO;
        end
        else if (winState == WIN_OPEN)
        begin
            // Expiry alone closes it; an interrupted unlock just wastes the time
            if (winTimer == CNT_W'(CFG_WIN_CYCLES - 1))
                winState <= WIN_CLOSED;
            winTimer <= winTimer + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            written <= '0;
        else if (unlockOk)
            written <= '0;
        else if (wrOk)
            written[cfgSel] <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-once registers
    always_comb
    begin
        next_ctrl = cfgData;
        // Locked watchdog stays on even if a stale write tries to clear it
        if (ctrlReg[CTRL_EN] && !ctrlReg[CTRL_UPD])
            next_ctrl[CTRL_EN] = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            ctrlReg <= CTRL_RESET;
        else if (wrOk && cfgSel == REG_CTRL)
            ctrlReg <= next_ctrl;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            timeoutVal <= TIMEOUT_RESET;
        else if (wrOk && cfgSel == REG_TOH)
            timeoutVal[CNT_W-1:BYTE_W] <= cfgData;
        else if (wrOk && cfgSel == REG_TOL)
            timeoutVal[BYTE_W-1:0] <= cfgData;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            windowVal <= WINDOW_RESET;
        else if (wrOk && cfgSel == REG_WINH)
            windowVal[CNT_W-1:BYTE_W] <= cfgData;
        else if (wrOk && cfgSel == REG_WINL)
            windowVal[BYTE_W-1:0] <= cfgData;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter, refresh and timeout
    assign tickIf.srcSel  = ctrlReg[CTRL_CLKSEL];
    assign tickIf.divSel  = ctrlReg[CTRL_PRESC];
    assign tickIf.extTick = extTick;
    assign tick           = tickIf.tick;

    wdw_tick_gen u_tick (
        .core_clk (core_clk),
        .rstN     (rstN),
        .bus      (tickIf.gen)
    );

    // Counting pauses while the configuration window is open
    assign counterRunningFlag = ctrlReg[CTRL_EN] && winState == WIN_CLOSED;
    assign refreshBad = counterRunningFlag && refreshReq && ctrlReg[CTRL_WINEN]
                        && counterValue < windowVal;
    assign refreshOk  = counterRunningFlag && refreshReq && !refreshBad;
    // A good refresh in the same cycle as the last tick still saves the system
    assign timeoutEv  = counterRunningFlag && tick && !refreshOk
                        && counterValue >= timeoutVal;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            counterValue <= CNT_ZERO;
        else if (refreshOk || timeoutEv || unlockOk)
            counterValue <= CNT_ZERO;
        else if (counterRunningFlag && tick)
            counterValue <= counterValue + CNT_ONE;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            systemReset <= 1'b0;
        else
            systemReset <= timeoutEv || refreshBad;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            timeoutIrqFlag <= 1'b0;
        else if (timeoutEv && ctrlReg[CTRL_IRQEN])
            timeoutIrqFlag <= 1'b1;
        else if (irqFlagClear)
            timeoutIrqFlag <= 1'b0;
    end

    assign timeoutIrqReq    = timeoutIrqFlag && ctrlReg[CTRL_IRQEN];
    assign configWindowOpen = winState == WIN_OPEN;
    assign updateAllowed    = ctrlReg[CTRL_UPD];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    write_once_a: assert property (
        cfgWr && cfgSel == REG_TOL && written[REG_TOL] |=> $stable(timeoutVal))
        else $error("second timeout write in one window took effect");
    closed_ignore_a: assert property (
        winState == WIN_CLOSED && !unlockReq
        |=> $stable(ctrlReg) && $stable(timeoutVal) && $stable(windowVal))
        else $error("configuration changed while window closed");
    relock_a: assert property (
        winState == WIN_CLOSED && !ctrlReg[CTRL_UPD] |=> winState == WIN_CLOSED)
        else $error("window reopened without update allowed");
    timeout_reset_a: assert property (
        counterRunningFlag && tick && counterValue >= timeoutVal && !refreshReq
        |=> systemReset && counterValue == CNT_ZERO)
        else $error("timeout did not raise system reset");
    stay_on_a: assert property (
        ctrlReg[CTRL_EN] && !ctrlReg[CTRL_UPD] |=> ctrlReg[CTRL_EN])
        else $error("locked watchdog was switched off");
    early_refresh_a: assert property (
        counterRunningFlag && ctrlReg[CTRL_WINEN] && refreshReq && counterValue < windowVal
        |=> systemReset)
        else $error("early refresh not punished");
    timeout_hi_a: assert property (
        wrOk && cfgSel == REG_TOH |=> timeoutVal[CNT_W-1:BYTE_W] == $past(cfgData))
        else $error("timeout high byte not stored");
    irq_flag_a: assert property (
        timeoutEv && ctrlReg[CTRL_IRQEN] |=> timeoutIrqFlag)
        else $error("interrupt flag not set on timeout");
    flag_hold_a: assert property (
        timeoutIrqFlag && !irqFlagClear |=> timeoutIrqFlag)
        else $error("interrupt flag dropped without clear");
    flag_clear_a: assert property (
        timeoutIrqFlag && irqFlagClear && !timeoutEv |=> !timeoutIrqFlag)
        else $error("interrupt flag not cleared");
    refresh_zero_a: assert property (
        refreshOk |=> counterValue == CNT_ZERO)
        else $error("refresh did not clear counter");
    stopped_hold_a: assert property (
        !counterRunningFlag && !unlockReq |=> $stable(counterValue))
        else $error("counter moved while not running");

    timeout_c: cover property (timeoutEv ##1 systemReset);
    refresh_c: cover property (refreshOk ##1 counterValue == CNT_ZERO);
    reopen_c:  cover property (winState == WIN_CLOSED ##1 unlockOk ##1 winState == WIN_OPEN);

endmodule
`default_nettype wire

// File: src/wdw_pkg.sv
// Constants shared by the windowed watchdog and its tick generator
package wdw_pkg;

    localparam int CNT_W  = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W  = 3;
    localparam int PRE_W  = 8;

    // Byte register selects
    localparam logic [SEL_W-1:0] REG_CTRL = 3'h0;
    localparam logic [SEL_W-1:0] REG_TOH  = 3'h1;
    localparam logic [SEL_W-1:0] REG_TOL  = 3'h2;
    localparam logic [SEL_W-1:0] REG_WINH = 3'h3;
    localparam logic [SEL_W-1:0] REG_WINL = 3'h4;
    localparam int               NUM_REGS = 5;

    // Control byte layout
    localparam int CTRL_EN     = 0;
    localparam int CTRL_UPD    = 1;
    localparam int CTRL_IRQEN  = 2;
    localparam int CTRL_WINEN  = 3;
    localparam int CTRL_CLKSEL = 4;
    localparam int CTRL_PRESC  = 5;

    // Reset values: enabled, updates allowed, longest timeout
    localparam logic [BYTE_W-1:0] CTRL_RESET    = 8'h03;
    localparam logic [CNT_W-1:0]  TIMEOUT_RESET = 16'hFFFF;
    localparam logic [CNT_W-1:0]  WINDOW_RESET  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ZERO      = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE       = 16'h0001;
    localparam logic [PRE_W-1:0]  PRE_LAST      = 8'hFF;
    localparam logic [PRE_W-1:0]  PRE_ONE       = 8'h01;
    localparam logic [PRE_W-1:0]  PRE_ZERO      = 8'h00;

    // Configuration window length
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CFG_WIN_TIME_NS = 2560;
    localparam int CFG_WIN_CYCLES  = CFG_WIN_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic {WIN_OPEN, WIN_CLOSED} wdw_win_e;

endpackage

// File: src/wdw_tick_if.sv
// Carrier between the watchdog core and its tick generator
`timescale 1ns/1ps
`default_nettype none
interface wdw_tick_if;
    logic srcSel;
    logic divSel;
    logic extTick;
    logic tick;

    modport ctl (output srcSel, output divSel, output extTick, input tick);
    modport gen (input srcSel, input divSel, input extTick, output tick);
endinterface
`default_nettype wire

// File: src/wdw_tick_gen.sv
// Watchdog tick source selection and prescaler
`timescale 1ns/1ps
`default_nettype none
module wdw_tick_gen
    import wdw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstN,
    wdw_tick_if.gen  bus
);

    logic [PRE_W-1:0] preCnt;
    logic             srcTick;

    // Source one ticks every core cycle; source two follows the external strobe
    assign srcTick = bus.srcSel ? bus.extTick : 1'b1;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            preCnt <= PRE_ZERO;
        else if (srcTick)
            preCnt <= preCnt + PRE_ONE;
    end

    assign bus.tick = bus.divSel ? (srcTick && preCnt == PRE_LAST) : srcTick;

endmodule
`default_nettype wire

// File: verification/wdw_watchdog_tb.sv
// Self-checking bench for the windowed watchdog, driven through its plain ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) compares++; if ((g) !== (e)) begin numErrors++; $display("wrong value at %0t ns: %s", $time, m); end
module wdw_watchdog_tb
    import wdw_pkg::*;
;
    logic              core_clk     = 1'b0;
    logic              rst_b        = 1'b0;
    logic              unlockReq    = 1'b0;
    logic              refreshReq   = 1'b0;
    logic              cfgWr        = 1'b0;
    logic [SEL_W-1:0]  cfgSel       = REG_CTRL;
    logic [BYTE_W-1:0] cfgData      = 8'h00;
    logic              irqFlagClear = 1'b0;
    logic              extTick      = 1'b0;
    logic              configWindowOpen;
    logic              updateAllowed;
    logic              timeoutIrqFlag;
    logic              timeoutIrqReq;
    logic              counterRunningFlag;
    logic [CNT_W-1:0]  counterValue;
    logic              systemReset;
    int                numErrors    = 0;
    int                compares     = 0;
    int                cyc          = 0;
    int                unlockAt     = 0;
    int                gap          = 0;

    ////////////////////////////////////////////////////////////////////////////////
    wdw_watchdog dut (
        .core_clk           (core_clk),
        .rst_b              (rst_b),
        .unlockReq          (unlockReq),
        .refreshReq         (refreshReq),
        .cfgWr              (cfgWr),
        .cfgSel             (cfgSel),
        .cfgData            (cfgData),
        .irqFlagClear       (irqFlagClear),
        .extTick            (extTick),
        .configWindowOpen   (configWindowOpen),
        .updateAllowed      (updateAllowed),
        .timeoutIrqFlag     (timeoutIrqFlag),
        .timeoutIrqReq      (timeoutIrqReq),
        .counterRunningFlag (counterRunningFlag),
        .counterValue       (counterValue),
        .systemReset        (systemReset)
    );

    always #5 core_clk = ~core_clk;

    // Whole run needs about 2000 cycles; generous ceiling
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            numErrors++;
            finalReport();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finalReport;
        $display("Comparisons %0d, mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Kind 0 unlock, 1 refresh, 2 flag clear; only the raised strobe is touched
    task automatic pulse(input int kind);
        case (kind)
            0:       unlockReq    = 1'b1;
            1:       refreshReq   = 1'b1;
            default: irqFlagClear = 1'b1;
        endcase
        @(negedge core_clk);
        case (kind)
            0:       unlockReq    = 1'b0;
            1:       refreshReq   = 1'b0;
            default: irqFlagClear = 1'b0;
        endcase
    endtask

    // Caller lowers rst_b; three low cycles, then the two-flop release settles
    task automatic holdReset;
        repeat (3) @(negedge core_clk);
        `CHK(counterRunningFlag, 1'b0, "running during reset")
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK(configWindowOpen, 1'b1, "window shut after reset")
        `CHK(updateAllowed, 1'b1, "update bit not reset")
        `CHK(counterValue, 16'h0000, "counter not reset")
        `CHK(timeoutIrqFlag, 1'b0, "flag not reset")
    endtask

    // Idle cycle after each write so strobes never retoggle in one step
    task automatic cfgWrite(input logic [SEL_W-1:0] sel, input logic [BYTE_W-1:0] data);
        cfgWr   = 1'b1;
        cfgSel  = sel;
        cfgData = data;
        @(negedge core_clk);
        cfgWr   = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic waitCnt(input logic [CNT_W-1:0] val);
        int n;
        n = 0;
        while (counterValue !== val && n < 1000)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK(counterValue, val, "counter never reached target")
    endtask

    task automatic waitClose;
        int n;
        n = 0;
        while (configWindowOpen === 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK(configWindowOpen, 1'b0, "window never closed")
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        holdReset();
        cfgWrite(REG_TOH, 8'h00);
        cfgWrite(REG_TOL, 8'h05);
        cfgWrite(REG_TOL, 8'h40);
        cfgWrite(REG_CTRL, 8'h07);
        waitClose();
        `CHK(counterRunningFlag, 1'b1, "not running after window")
        waitCnt(16'h0005);
        @(negedge core_clk);
        `CHK(systemReset, 1'b1, "no reset on timeout")
        `CHK(counterValue, 16'h0000, "counter kept after timeout")
        `CHK(timeoutIrqReq, 1'b1, "no interrupt on timeout")
        @(negedge core_clk);
        `CHK(systemReset, 1'b0, "reset pulse too long")
        `CHK(timeoutIrqFlag, 1'b1, "flag not sticky")
        pulse(2);
        `CHK(timeoutIrqFlag, 1'b0, "flag not cleared")
        waitCnt(16'h0003);
        pulse(1);
        `CHK(counterValue, 16'h0000, "refresh kept count")
        `CHK(systemReset, 1'b0, "good refresh reset")
        // Second window: window mode, longer timeout
        pulse(0);
        unlockAt = cyc;
        `CHK(configWindowOpen, 1'b1, "unlock refused")
        `CHK(counterValue, 16'h0000, "unlock kept count")
        cfgWrite(REG_CTRL, 8'h0B);
        cfgWrite(REG_TOL, 8'h10);
        cfgWrite(REG_WINL, 8'h04);
        cfgWrite(REG_WINH, 8'h00);
        waitClose();
        `CHK(cyc - unlockAt, CFG_WIN_CYCLES, "window length")
        waitCnt(16'h0002);
        pulse(1);
        `CHK(systemReset, 1'b1, "early refresh accepted")
        cfgWrite(REG_TOL, 8'h02);
        waitCnt(16'h0008);
        pulse(1);
        `CHK(counterValue, 16'h0000, "in-window refresh lost")
        `CHK(systemReset, 1'b0, "in-window refresh reset")
        // Third window: shut down and lock
        pulse(0);
        cfgWrite(REG_CTRL, 8'h00);
        waitClose();
        repeat (4) @(negedge core_clk);
        `CHK(counterRunningFlag, 1'b0, "still running when off")
        `CHK(counterValue, 16'h0000, "counting when off")
        `CHK(updateAllowed, 1'b0, "update bit kept")
        pulse(0);
        `CHK(configWindowOpen, 1'b0, "locked unlock accepted")
        // Mid-run reset lifts the lock; then the external tick source
        rst_b = 1'b0;
        holdReset();
        cfgWrite(REG_CTRL, 8'h13);
        waitClose();
        extTick = 1'b1;
        repeat (3) @(negedge core_clk);
        extTick = 1'b0;
        `CHK(counterValue, 16'h0003, "external ticks not counted")
        repeat (5) @(negedge core_clk);
        `CHK(counterValue, 16'h0003, "counted without external tick")
        // Core clock divided by 256, locked on the way
        pulse(0);
        `CHK(counterValue, 16'h0000, "unlock kept count")
        cfgWrite(REG_CTRL, 8'h21);
        waitClose();
        `CHK(updateAllowed, 1'b0, "lock bit not taken")
        `CHK(counterRunningFlag, 1'b1, "locked watchdog not running")
        waitCnt(16'h0001);
        while (counterValue === 16'h0001 && gap < 300)
        begin
            @(negedge core_clk);
            gap++;
        end
        `CHK(gap, 256, "prescaled tick spacing")
        `CHK(counterValue, 16'h0002, "prescaled count lost")
        finalReport();
    end
endmodule
`default_nettype wire
